// ===== verilog/cmbe_exec.sv
`timescale 1ns/1ps
module cmbe_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [cmbe_pkg::IW-1:0] instr_word,
    input wire logic [cmbe_pkg::DW-1:0] pc_high_holding_latch,
    input wire logic [cmbe_pkg::DW-1:0] fsr0_ptr,
    input wire logic [cmbe_pkg::DW-1:0] fsr1_ptr,
    input wire logic [cmbe_pkg::DW-1:0] dm_rd_data,
    output logic [cmbe_pkg::PW-1:0] prog_addr,
    output cmbe_pkg::cmbe_phase_e phase,
    output cmbe_pkg::cmbe_dmem_s dm,
    output cmbe_pkg::cmbe_stack_s stack_top,
    output logic [cmbe_pkg::DW-1:0] working_register,
    output logic [cmbe_pkg::DW-1:0] bank_select_register,
    output logic zero_flag,
    output logic call_idle
);

    logic [cmbe_pkg::IW-1:0] ir;
    logic [cmbe_pkg::DW-1:0] operand;
    logic [cmbe_pkg::DW-1:0] result;
    cmbe_pkg::cmbe_phase_e next_phase;
    cmbe_pkg::cmbe_dec_s dec_in;
    cmbe_pkg::cmbe_dec_s dec;

    function automatic cmbe_pkg::cmbe_dec_s decode(input logic [cmbe_pkg::IW-1:0] w);
        cmbe_pkg::cmbe_dec_s d;
        d.long_subroutine_call =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_CALL);
        d.move_data_to_periph_space =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP3_LO] == cmbe_pkg::OPC_TO_PERIPH);
        // unused nibble never looked at
        d.load_bank_low_nibble =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_BANK_LO);
        // bit 8 and the low nibble never looked at
        d.load_bank_high_nibble =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP7_LO] == cmbe_pkg::OPC_BANK_HI);
        d.load_literal_to_working =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_LIT_W);
        d.or_working_with_file =
            (w[cmbe_pkg::OP_HI:cmbe_pkg::OP7_LO] == cmbe_pkg::OPC_OR_FILE);
        return d;
    endfunction

    // indirect locations are replaced by their pointer
    function automatic logic [cmbe_pkg::DW-1:0] eff_addr(input logic [cmbe_pkg::DW-1:0] a,
                                                          input logic [cmbe_pkg::DW-1:0] p0,
                                                          input logic [cmbe_pkg::DW-1:0] p1);
        logic [cmbe_pkg::DW-1:0] r;
        r = a;
        if (a == cmbe_pkg::INDIRECT0_ADDR) begin
            r = p0;
        end else if (a == cmbe_pkg::INDIRECT1_ADDR) begin
            r = p1;
        end
        return r;
    endfunction

    logic [cmbe_pkg::DW-1:0] src_addr;
    logic [cmbe_pkg::DW-1:0] dst_addr;
    logic [cmbe_pkg::DW-1:0] lit;
    logic dest_file;

    assign dec_in = decode(instr_word);
    assign dec = decode(ir);
    assign lit = ir[cmbe_pkg::DW-1:0];
    assign dest_file = ir[cmbe_pkg::DEST_BIT];
    assign src_addr = ir[cmbe_pkg::DW-1:0];
    assign dst_addr = dec.move_data_to_periph_space ?
        {3'h0, ir[cmbe_pkg::PADDR_HI:cmbe_pkg::PADDR_LO]} : ir[cmbe_pkg::DW-1:0];

    always_comb begin
        case (phase)
            cmbe_pkg::CMBE_Q1: next_phase = cmbe_pkg::CMBE_Q2;
            cmbe_pkg::CMBE_Q2: next_phase = cmbe_pkg::CMBE_Q3;
            cmbe_pkg::CMBE_Q3: next_phase = cmbe_pkg::CMBE_Q4;
            cmbe_pkg::CMBE_Q4: next_phase = cmbe_pkg::CMBE_Q1;
            default: next_phase = cmbe_pkg::CMBE_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= cmbe_pkg::CMBE_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // instruction latch; the word fetched behind a call is dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir <= cmbe_pkg::IDLE_WORD;
        end else if (phase == cmbe_pkg::CMBE_Q1) begin
            ir <= call_idle ? cmbe_pkg::IDLE_WORD : instr_word;
        end
    end

    // return address goes out in Q2, well before the jump at the end of Q4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_top <= '0;
        end else if (phase == cmbe_pkg::CMBE_Q1) begin
            stack_top.push <= dec_in.long_subroutine_call && !call_idle;
            stack_top.data <= prog_addr + 16'h0001;
        end else begin
            stack_top.push <= 1'b0;
        end
    end

    // data-space port: read in Q2, write in Q4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dm <= '0;
        end else begin
            case (phase)
                cmbe_pkg::CMBE_Q1: begin
                    dm.rd_en <= (dec_in.move_data_to_periph_space ||
                                 dec_in.or_working_with_file) && !call_idle;
                    dm.rd_addr <= eff_addr(instr_word[cmbe_pkg::DW-1:0],
                                           fsr0_ptr, fsr1_ptr);
                end
                cmbe_pkg::CMBE_Q2: begin
                    dm.rd_en <= 1'b0;
                end
                cmbe_pkg::CMBE_Q3: begin
                    dm.wr_en <= (dec.move_data_to_periph_space ||
                                 (dec.or_working_with_file && dest_file)) &&
                                dst_addr != cmbe_pkg::WORKING_ADDR;
                    dm.wr_addr <= eff_addr(dst_addr, fsr0_ptr, fsr1_ptr);
                    dm.wr_data <= dec.or_working_with_file ? (working_register | operand) :
                                  operand;
                end
                cmbe_pkg::CMBE_Q4: begin
                    dm.wr_en <= 1'b0;
                end
                default: begin
                    dm.wr_en <= 1'b0;
                end
            endcase
        end
    end

    // operand fetch; the working register is read in place of its location
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operand <= '0;
        end else if (phase == cmbe_pkg::CMBE_Q2) begin
            operand <= (src_addr == cmbe_pkg::WORKING_ADDR) ? working_register :
                       dm_rd_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (phase == cmbe_pkg::CMBE_Q3) begin
            result <= dec.or_working_with_file ? (working_register | operand) : operand;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register <= cmbe_pkg::WORKING_RESET;
        end else if (phase == cmbe_pkg::CMBE_Q4) begin
            if (dec.load_literal_to_working) begin
                working_register <= lit;
            end else if (dec.or_working_with_file &&
                         (!dest_file || dst_addr == cmbe_pkg::WORKING_ADDR)) begin
                working_register <= result;
            end else if (dec.move_data_to_periph_space &&
                         dst_addr == cmbe_pkg::WORKING_ADDR) begin
                working_register <= result;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_register <= cmbe_pkg::BANK_RESET;
        end else if (phase == cmbe_pkg::CMBE_Q4) begin
            if (dec.load_bank_low_nibble) begin
                bank_select_register[cmbe_pkg::BANK_LO_LIT_HI:0] <=
                    ir[cmbe_pkg::BANK_LO_LIT_HI:0];
            end else if (dec.load_bank_high_nibble) begin
                bank_select_register[cmbe_pkg::DW-1:cmbe_pkg::BANK_HI_LIT_LO] <=
                    ir[cmbe_pkg::BANK_HI_LIT_HI:cmbe_pkg::BANK_HI_LIT_LO];
            end
        end
    end

    // only the OR touches the zero flag here; moves leave it alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag <= cmbe_pkg::ZERO_RESET;
        end else if (phase == cmbe_pkg::CMBE_Q4 && dec.or_working_with_file) begin
            zero_flag <= (result == 8'h00);
        end
    end

    // jump lands at the end of Q4; the pc holds through the idle cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr <= cmbe_pkg::PC_RESET;
        end else if (phase == cmbe_pkg::CMBE_Q4 && !call_idle) begin
            if (dec.long_subroutine_call) begin
                prog_addr <= {pc_high_holding_latch, lit};
            end else begin
                prog_addr <= prog_addr + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            call_idle <= 1'b0;
        end else if (phase == cmbe_pkg::CMBE_Q4) begin
            call_idle <= dec.long_subroutine_call && !call_idle;
        end
    end

    sequence s_call_taken;
        phase == cmbe_pkg::CMBE_Q1 && dec_in.long_subroutine_call && !call_idle;
    endsequence

    sequence s_idle_cycle;
        call_idle [*4] ##1 !call_idle;
    endsequence

    a_call_push_first: assert property (@(posedge clk) disable iff (!rst_n)
        s_call_taken |=> stack_top.push && stack_top.data == $past(prog_addr) + 16'h0001
            && $stable(prog_addr)
            ##1 !stack_top.push ##2 stack_top.data == $past(prog_addr, 4) + 16'h0001)
        else $error("call did not push the return address first");

    a_call_target: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.long_subroutine_call && !call_idle
        |=> prog_addr == {$past(pc_high_holding_latch), $past(ir[7:0])})
        else $error("call target is wrong");

    a_call_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        s_call_taken |=> ##3 s_idle_cycle)
        else $error("call did not take exactly two cycles");

    a_idle_no_write: assert property (@(posedge clk) disable iff (!rst_n)
        call_idle |-> !dm.wr_en && !stack_top.push ##1 $stable(prog_addr))
        else $error("activity during the idle call cycle");

    a_periph_move_data: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.move_data_to_periph_space && dm.wr_en
        |-> dm.wr_data == operand ##1 $stable(zero_flag))
        else $error("peripheral move data or flag wrong");

    a_periph_move_addr: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.move_data_to_periph_space &&
        dst_addr != cmbe_pkg::WORKING_ADDR
        |-> dm.wr_en && dm.wr_addr == eff_addr(dst_addr, $past(fsr0_ptr), $past(fsr1_ptr)))
        else $error("peripheral move address wrong");

    a_bank_low_load: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.load_bank_low_nibble
        |=> bank_select_register == {$past(bank_select_register[7:4]), $past(ir[3:0])})
        else $error("low bank load wrong");

    a_bank_high_load: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.load_bank_high_nibble
        |=> bank_select_register == {$past(ir[7:4]), $past(bank_select_register[3:0])})
        else $error("high bank load wrong");

    a_literal_load: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && instr_word[15:8] == 8'hB0 && !call_idle
        |=> ##3 working_register == $past(instr_word[7:0], 4))
        else $error("literal load wrong");

    a_or_to_working: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q4 && dec.or_working_with_file && !dest_file
        |-> !dm.wr_en ##1 working_register == $past(result))
        else $error("OR with clear destination wrote the file");

    // these read the raw word, not the decoder, so a decode slip cannot hide itself

    a_call_uncond: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && !call_idle &&
        instr_word[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_CALL
        |=> stack_top.push ##3
            prog_addr == {$past(pc_high_holding_latch), $past(instr_word[7:0], 4)})
        else $error("call opcode was not taken");

    a_idle_word_drop: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && call_idle |=> ir == cmbe_pkg::IDLE_WORD)
        else $error("word behind a call was not dropped");

    a_bank_low_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && !call_idle &&
        instr_word[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_BANK_LO
        |=> ##3 bank_select_register[3:0] == $past(instr_word[3:0], 4))
        else $error("low bank load depends on unused bits");

    a_bank_high_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && !call_idle &&
        instr_word[cmbe_pkg::OP_HI:cmbe_pkg::OP7_LO] == cmbe_pkg::OPC_BANK_HI
        |=> ##3 bank_select_register[7:4] == $past(instr_word[7:4], 4))
        else $error("high bank load depends on unused bits");

    // a literal load must not disturb the data space, or it would cost a cycle
    a_literal_no_mem: assert property (@(posedge clk) disable iff (!rst_n)
        phase == cmbe_pkg::CMBE_Q1 && !call_idle &&
        instr_word[cmbe_pkg::OP_HI:cmbe_pkg::OP8_LO] == cmbe_pkg::OPC_LIT_W
        |=> !dm.rd_en ##2 !dm.wr_en)
        else $error("literal load touched data memory");

endmodule

// ===== verilog/cmbe_pkg.sv
package cmbe_pkg;

    localparam int DW = 8;
    localparam int IW = 16;
    localparam int PW = 16;

    // opcode fields
    localparam logic [7:0] OPC_CALL = 8'hB7;
    localparam logic [7:0] OPC_BANK_LO = 8'hB8;
    localparam logic [6:0] OPC_BANK_HI = 7'h5D;
    localparam logic [7:0] OPC_LIT_W = 8'hB0;
    localparam logic [2:0] OPC_TO_PERIPH = 3'h3;
    localparam logic [6:0] OPC_OR_FILE = 7'h04;
    localparam logic [IW-1:0] IDLE_WORD = 16'h0000;

    // field positions
    localparam int OP_HI = 15;
    localparam int OP8_LO = 8;
    localparam int OP7_LO = 9;
    localparam int OP3_LO = 13;
    localparam int DEST_BIT = 8;
    localparam int PADDR_HI = 12;
    localparam int PADDR_LO = 8;
    localparam int BANK_HI_LIT_HI = 7;
    localparam int BANK_HI_LIT_LO = 4;
    localparam int BANK_LO_LIT_HI = 3;

    // data-space locations with special meaning; values are a plain choice
    localparam logic [DW-1:0] WORKING_ADDR = 8'h0A;
    localparam logic [DW-1:0] INDIRECT0_ADDR = 8'h00;
    localparam logic [DW-1:0] INDIRECT1_ADDR = 8'h08;

    // values after reset
    localparam logic [PW-1:0] PC_RESET = 16'h0000;
    localparam logic [DW-1:0] WORKING_RESET = 8'h00;
    localparam logic [DW-1:0] BANK_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;

    // quarter phases of one instruction cycle, Gray order
    typedef enum logic [1:0] {
        CMBE_Q1 = 2'b00,
        CMBE_Q2 = 2'b01,
        CMBE_Q3 = 2'b11,
        CMBE_Q4 = 2'b10
    } cmbe_phase_e;

    typedef struct packed {
        logic long_subroutine_call;
        logic move_data_to_periph_space;
        logic load_bank_low_nibble;
        logic load_bank_high_nibble;
        logic load_literal_to_working;
        logic or_working_with_file;
    } cmbe_dec_s;

    typedef struct packed {
        logic rd_en;
        logic [DW-1:0] rd_addr;
        logic wr_en;
        logic [DW-1:0] wr_addr;
        logic [DW-1:0] wr_data;
    } cmbe_dmem_s;

    typedef struct packed {
        logic push;
        logic [PW-1:0] data;
    } cmbe_stack_s;

endpackage

// ===== testbench/call_move_bank_instr_exec_tb.sv
`timescale 1ns/1ps
module call_move_bank_instr_exec_tb;
    typedef struct packed {
        logic [15:0] word;
        logic [7:0] w;
        logic [7:0] bank;
        logic zero;
        logic [1:0] nwr;
        logic [7:0] wa;
        logic [7:0] wd;
    } cmbe_row_s;
    logic clk;
    logic rst_n;
    logic [15:0] instr_word;
    logic [7:0] pc_high_holding_latch;
    logic [7:0] fsr0_ptr;
    logic [7:0] fsr1_ptr;
    logic [7:0] dm_rd_data;
    logic [15:0] prog_addr;
    cmbe_pkg::cmbe_phase_e phase;
    cmbe_pkg::cmbe_dmem_s dm;
    cmbe_pkg::cmbe_stack_s stack_top;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
    logic zero_flag;
    logic call_idle;
    logic [7:0] mem [256];
    logic [7:0] wa;
    logic [7:0] wd;
    logic [15:0] push_data;
    logic [15:0] pc0;
    int n_wr;
    int n_push;
    int n_errors;
    int total_checks;
    int cycles;
    cmbe_row_s rows [14];
    cmbe_exec dut (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
        .pc_high_holding_latch(pc_high_holding_latch), .fsr0_ptr(fsr0_ptr),
        .fsr1_ptr(fsr1_ptr), .dm_rd_data(dm_rd_data), .prog_addr(prog_addr), .phase(phase),
        .dm(dm), .stack_top(stack_top), .working_register(working_register),
        .bank_select_register(bank_select_register), .zero_flag(zero_flag),
        .call_idle(call_idle));
    // outside a read the memory shows inverted data, so a late sample cannot pass
    assign dm_rd_data = dm.rd_en ? mem[dm.rd_addr] : ~mem[dm.rd_addr];
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (dm.wr_en === 1'b1) begin
            mem[dm.wr_addr] <= dm.wr_data;
            wa <= dm.wr_addr;
            wd <= dm.wr_data;
            n_wr <= n_wr + 1;
        end
        if (stack_top.push === 1'b1) begin
            push_data <= stack_top.data;
            n_push <= n_push + 1;
        end
    end
    always @(posedge clk) begin
        if (cycles > 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (exp !== got) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic run(input logic [15:0] w);
        int k;
        k = 0;
        while (phase !== cmbe_pkg::CMBE_Q1 && k < 8) begin
            @(posedge clk);
            #5;
            k++;
        end
        instr_word = w;
        repeat (4) @(posedge clk);
        #5;
    endtask
    task automatic results();
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_reset();
        chk("phase", 16'(cmbe_pkg::CMBE_Q1), 16'(phase));
        chk("prog_addr", cmbe_pkg::PC_RESET, prog_addr);
        chk("working", 16'(cmbe_pkg::WORKING_RESET), 16'(working_register));
        chk("bank", 16'(cmbe_pkg::BANK_RESET), 16'(bank_select_register));
        chk("zero", 16'(cmbe_pkg::ZERO_RESET), 16'(zero_flag));
        chk("idle", 16'h0000, 16'(call_idle));
    endtask
    initial begin
        rows = '{
            '{16'hB000, 8'h00, 8'h00, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'h08F0, 8'h00, 8'h00, 1'b1, 2'h0, 8'h00, 8'h00},
            '{16'h7225, 8'h00, 8'h00, 1'b1, 2'h1, 8'h12, 8'h25},
            '{16'hB091, 8'h91, 8'h00, 1'b1, 2'h0, 8'h00, 8'h00},
            '{16'h0813, 8'h93, 8'h00, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'hB825, 8'h93, 8'h05, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'hBA50, 8'h93, 8'h55, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'hBB3F, 8'h93, 8'h35, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'hB8F0, 8'h93, 8'h30, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'h7F0A, 8'h93, 8'h30, 1'b0, 2'h1, 8'h1F, 8'h93},
            '{16'h6A44, 8'h44, 8'h30, 1'b0, 2'h0, 8'h00, 8'h00},
            '{16'h7800, 8'h44, 8'h30, 1'b0, 2'h1, 8'h18, 8'h60},
            '{16'h6830, 8'h44, 8'h30, 1'b0, 2'h1, 8'h70, 8'h30},
            '{16'h0915, 8'h44, 8'h30, 1'b0, 2'h1, 8'h15, 8'h55}};
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i);
        end
        mem[8'hF0] = 8'h00;
        rst_n = 1'b0;
        instr_word = 16'h0000;
        pc_high_holding_latch = 8'hC3;
        fsr0_ptr = 8'h60;
        fsr1_ptr = 8'h70;
        n_wr = 0;
        n_push = 0;
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        #5;
        chk_reset();
        rst_n = 1'b1;
        for (int i = 0; i < 14; i++) begin
            pc0 = prog_addr;
            n_wr = 0;
            run(rows[i].word);
            chk("working", 16'(rows[i].w), 16'(working_register));
            chk("bank", 16'(rows[i].bank), 16'(bank_select_register));
            chk("zero", 16'(rows[i].zero), 16'(zero_flag));
            chk("writes", 16'(rows[i].nwr), 16'(n_wr));
            if (rows[i].nwr != 2'h0) begin
                chk("wr_addr", 16'(rows[i].wa), 16'(wa));
                chk("wr_data", 16'(rows[i].wd), 16'(wd));
            end
            chk("prog_addr", pc0 + 16'h0001, prog_addr);
        end
        chk("push", 16'h0000, 16'(n_push));
        // two calls: one mid-range, one to the very top of program space
        for (int j = 0; j < 2; j++) begin
            pc_high_holding_latch = (j == 0) ? 8'hC3 : 8'hFF;
            run(16'hB055);
            pc0 = prog_addr;
            n_push = 0;
            n_wr = 0;
            run((j == 0) ? 16'hB740 : 16'hB7FF);
            chk("push", 16'h0001, 16'(n_push));
            chk("push_data", pc0 + 16'h0001, push_data);
            chk("target", (j == 0) ? 16'hC340 : 16'hFFFF, prog_addr);
            chk("idle", 16'h0001, 16'(call_idle));
            pc0 = prog_addr;
            run(16'hB0EE);
            chk("working", 16'h0055, 16'(working_register));
            chk("idle", 16'h0000, 16'(call_idle));
            chk("prog_addr", pc0, prog_addr);
            chk("writes", 16'h0000, 16'(n_wr));
            run(16'hB011);
            chk("working", 16'h0011, 16'(working_register));
            chk("prog_addr", pc0 + 16'h0001, prog_addr);
        end
        // reset in mid-instruction returns everything at once
        @(posedge clk);
        #5;
        rst_n = 1'b0;
        #1;
        chk_reset();
        repeat (2) @(posedge clk);
        #5;
        rst_n = 1'b1;
        run(16'hB03C);
        chk("working", 16'h003C, 16'(working_register));
        chk("prog_addr", cmbe_pkg::PC_RESET + 16'h0001, prog_addr);
        results();
    end
endmodule
